/* rtl/adc_ctrl_pkg.sv */
// shared constants and types for the serial converter control front end
package adc_ctrl_pkg;
   // control byte layout
   localparam int CFG_BITS = 8;
   localparam int SEL_MSB_POS = 6;
   localparam int SEL_LSB_POS = 4;
   localparam int POL_POS = 3;
   localparam int PAIR_POS = 2;
   localparam int MODE_HI_POS = 1;
   localparam int MODE_LO_POS = 0;
   // power-up setup selects internal clock mode
   localparam logic [7:0] SETUP_RESET = 8'h02;
   // serial counts
   localparam logic [2:0] LAST_CFG_BIT = 3'h6;
   localparam int RESULT_BITS = 12;
   localparam logic [3:0] RESULT_COUNT = 4'hC;
   localparam logic [3:0] RESUME_COUNT = 4'h5;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [1:0] {
      MODE_FULL_PD,
      MODE_FAST_PD,
      MODE_INT_CLK,
      MODE_EXT_CLK
   } mode_e;

   typedef enum logic {
      RX_HUNT,
      RX_CONFIG
   } rx_e;

   // control byte without its start bit
   typedef struct packed {
      logic [2:0] channelSelect;
      logic polaritySelect;
      logic inputPairingSelect;
      mode_e modeSelect;
   } setup_s;

   // analog multiplexer routing
   typedef struct packed {
      logic [2:0] plusChannel;
      logic [2:0] minusChannel;
      logic minusGround;
   } route_s;
endpackage

/* rtl/bit_sync.sv */
// two flip-flop level synchroniser
module bit_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic stage1_ff;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_ff <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut <= stage1_ff;
      end
   end
endmodule

/* rtl/sample_fifo.sv */
// synchronous FIFO with registered flags
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;
   logic [AW:0] nxt_count;

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr_ff];
   assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

   // storage has no reset, only pointers, count and flags do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   // pointers, count and flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         inReady <= 1'b1;
         outValid <= 1'b0;
      end else begin
         if (push) begin
            wrPtr_ff <= AW'((wrPtr_ff + 1'b1) % DEPTH);
         end
         if (pop) begin
            rdPtr_ff <= AW'((rdPtr_ff + 1'b1) % DEPTH);
         end
         count_ff <= nxt_count;
         inReady <= nxt_count != (AW+1)'(DEPTH);
         outValid <= nxt_count != '0;
      end
   end
endmodule

/* rtl/adc_serial_control.sv */
// serial control byte front end of an eight channel converter
module adc_serial_control (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic shiftClk,
   input wire logic selectN,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutOe,
   output logic conversion_strobe_out,
   output logic strobeOe,
   input wire logic [adc_ctrl_pkg::RESULT_BITS-1:0] sampleData,
   input wire logic sampleValid,
   output logic sampleReady,
   output adc_ctrl_pkg::setup_s setup_ff,
   output adc_ctrl_pkg::route_s route_ff,
   output logic convStart_ff
);
   import adc_ctrl_pkg::*;

   // link domain: frame reset from select high or global reset
   logic frameRst;
   rx_e rxState_ff;
   logic [2:0] bitCnt_ff;
   logic [5:0] shiftIn_ff;
   logic startTog_ff;
   logic seenTog_ff;
   logic cfgTog_ff;
   logic [7:0] cfgByte_ff;
   logic [RESULT_BITS-1:0] resultSh_ff;
   logic [3:0] outCnt_ff;
   logic ackTog_ff;
   logic rxOpen;
   logic startFire;
   logic clockMode;
   logic haveWord;
   logic sendSync;
   mode_e cfgMode;
   logic [RESULT_BITS-1:0] loadWord;

   // reference domain
   logic ackSync;
   logic cfgSync;
   logic cfgSeen_ff;
   logic cfgNew;
   logic sendTog_ff;
   logic [RESULT_BITS-1:0] holdWord_ff;
   logic [RESULT_BITS-1:0] fifoData;
   logic fifoValid;
   logic fifoReady;
   setup_s newSetup;

   // select high clears the frame state at once, as the pins float then
   assign frameRst = selectN || !reset_n;
   assign cfgMode = mode_e'(cfgByte_ff[MODE_HI_POS:MODE_LO_POS]);
   assign startFire = startTog_ff != seenTog_ff;
   assign clockMode = (cfgMode == MODE_INT_CLK) || (cfgMode == MODE_EXT_CLK);
   assign haveWord = sendSync != ackTog_ff;
   // start reopens after bit five, fifteen clocks a conversion
   assign rxOpen = (outCnt_ff <= RESUME_COUNT) && !startFire && !conversion_strobe_out;

   // offset binary from the core, MSB flipped for two's complement
   always_comb begin
      loadWord = '0;
      if (haveWord) begin
         loadWord = holdWord_ff;
         loadWord[RESULT_BITS-1] = holdWord_ff[RESULT_BITS-1] ^ !cfgByte_ff[POL_POS];
      end
   end

   // start bit hunt and setup byte receive
   always_ff @(posedge shiftClk or posedge frameRst) begin
      if (frameRst) begin
         rxState_ff <= RX_HUNT;
         bitCnt_ff <= 3'h0;
         shiftIn_ff <= 6'h00;
         startTog_ff <= 1'b0;
      end else begin
         case (rxState_ff)
            RX_HUNT: begin
               if (serialIn && rxOpen) begin
                  rxState_ff <= RX_CONFIG;
                  bitCnt_ff <= 3'h0;
               end
            end
            RX_CONFIG: begin
               shiftIn_ff <= {shiftIn_ff[4:0], serialIn};
               bitCnt_ff <= bitCnt_ff + 3'h1;
               if (bitCnt_ff == LAST_CFG_BIT) begin
                  rxState_ff <= RX_HUNT;
                  startTog_ff <= ~startTog_ff;
               end
            end
            default: begin
               rxState_ff <= RX_HUNT;
            end
         endcase
      end
   end

   // whole byte latched at once; survives frame end
   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         cfgByte_ff <= SETUP_RESET;
         cfgTog_ff <= 1'b0;
      end else if (!selectN && rxState_ff == RX_CONFIG && bitCnt_ff == LAST_CFG_BIT) begin
         cfgByte_ff <= {1'b1, shiftIn_ff, serialIn};
         cfgTog_ff <= ~cfgTog_ff;
      end
   end

   // strobe pulse for one period in external mode
   always_ff @(negedge shiftClk or posedge frameRst) begin
      if (frameRst) begin
         conversion_strobe_out <= 1'b0;
         strobeOe <= 1'b0;
      end else begin
         strobeOe <= 1'b1;
         // strobe moves on falling edges only
         conversion_strobe_out <= startFire && (cfgMode == MODE_EXT_CLK);
      end
   end

   // conversion begins at the falling edge after bit eight
   always_ff @(negedge shiftClk or posedge frameRst) begin
      if (frameRst) begin
         seenTog_ff <= 1'b0;
         resultSh_ff <= '0;
         outCnt_ff <= 4'h0;
         serialOut <= 1'b0;
         serialOutOe <= 1'b0;
      end else begin
         serialOutOe <= 1'b1;
         if (startFire) begin
            seenTog_ff <= startTog_ff;
            serialOut <= 1'b0;
            if (clockMode) begin
               resultSh_ff <= loadWord;
               outCnt_ff <= RESULT_COUNT;
            end
         end else if (outCnt_ff != 4'h0) begin
            // MSB first, one bit per falling edge
            serialOut <= resultSh_ff[RESULT_BITS-1];
            resultSh_ff <= {resultSh_ff[RESULT_BITS-2:0], 1'b0};
            outCnt_ff <= outCnt_ff - 4'h1;
         end else begin
            // zeros pad the rest of the frame
            serialOut <= 1'b0;
         end
      end
   end

   // word hand-back to the reference side; outlives the frame
   always_ff @(negedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         ackTog_ff <= 1'b0;
      end else if (!selectN && startFire && clockMode && haveWord) begin
         ackTog_ff <= ~ackTog_ff;
      end
   end

   // word offered by the reference side
   bit_sync u_sendSync (
      .clk(shiftClk),
      .reset_n(reset_n),
      .asyncIn(sendTog_ff),
      .syncOut(sendSync)
   );

   // consumption acknowledge back to the reference side
   bit_sync u_ackSync (
      .clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(ackTog_ff),
      .syncOut(ackSync)
   );

   // new setup byte event
   bit_sync u_cfgSync (
      .clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(cfgTog_ff),
      .syncOut(cfgSync)
   );

   // results from the converter core wait here
   sample_fifo #(
      .WIDTH(RESULT_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .reset_n(reset_n),
      .inData(sampleData),
      .inValid(sampleValid),
      .inReady(sampleReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoReady)
   );

   // only one word in flight; the holding word stays still until acknowledged
   assign fifoReady = ackSync == sendTog_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sendTog_ff <= 1'b0;
         holdWord_ff <= '0;
      end else if (fifoValid && fifoReady) begin
         holdWord_ff <= fifoData;
         sendTog_ff <= ~sendTog_ff;
      end
   end

   // setup byte is stable for many shift periods after its toggle
   assign cfgNew = cfgSync != cfgSeen_ff;
   assign newSetup = setup_s'(cfgByte_ff[CFG_BITS-2:0]);

   function automatic route_s map_route(input setup_s s);
      route_s r;
      r = '0;
      if (s.inputPairingSelect) begin
         r.plusChannel = {s.channelSelect[1:0], s.channelSelect[2]};
         r.minusChannel = 3'h0;
         r.minusGround = 1'b1;
      end else begin
         // pair chosen by low bits, top bit swaps the sign
         r.plusChannel = {s.channelSelect[1:0], s.channelSelect[2]};
         r.minusChannel = {s.channelSelect[1:0], !s.channelSelect[2]};
         r.minusGround = 1'b0;
      end
      return r;
   endfunction

   // polarity, pairing, all fields land together
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfgSeen_ff <= 1'b0;
         setup_ff <= setup_s'(SETUP_RESET[CFG_BITS-2:0]);
         route_ff <= map_route(setup_s'(SETUP_RESET[CFG_BITS-2:0]));
         convStart_ff <= 1'b0;
      end else begin
         cfgSeen_ff <= cfgSync;
         convStart_ff <= 1'b0;
         if (cfgNew) begin
            setup_ff <= newSetup;
            route_ff <= map_route(newSetup);
            convStart_ff <= (newSetup.modeSelect == MODE_INT_CLK)
                            || (newSetup.modeSelect == MODE_EXT_CLK);
         end
      end
   end

   // link side checks
   property p_huntZeros;
      @(posedge shiftClk) disable iff (frameRst)
      (rxState_ff == RX_HUNT && !serialIn) |=> (rxState_ff == RX_HUNT);
   endproperty
   a_huntZeros: assert property (p_huntZeros)
      else $error("zero bit left the start hunt");

   property p_startBit;
      @(posedge shiftClk) disable iff (frameRst)
      (rxState_ff == RX_HUNT && serialIn && rxOpen)
         |=> (rxState_ff == RX_CONFIG && bitCnt_ff == 3'h0);
   endproperty
   a_startBit: assert property (p_startBit)
      else $error("start bit not taken");

   property p_cfgLatch;
      @(posedge shiftClk) disable iff (frameRst)
      (rxState_ff == RX_CONFIG && bitCnt_ff == 3'h6)
         |=> (cfgByte_ff[7] && cfgByte_ff[0] == $past(serialIn)
              && cfgByte_ff[6:1] == $past(shiftIn_ff));
   endproperty
   a_cfgLatch: assert property (p_cfgLatch)
      else $error("setup byte not captured from last bits");

   property p_cfgHold;
      @(posedge shiftClk) disable iff (frameRst)
      !(rxState_ff == RX_CONFIG && bitCnt_ff == 3'h6) |=> $stable(cfgByte_ff);
   endproperty
   a_cfgHold: assert property (p_cfgHold)
      else $error("setup changed on a partial byte");

   property p_extStart;
      @(negedge shiftClk) disable iff (frameRst)
      (startFire && cfgMode == MODE_EXT_CLK) |=> conversion_strobe_out;
   endproperty
   a_extStart: assert property (p_extStart)
      else $error("no strobe after eighth bit");

   property p_strobeMsb;
      @(negedge shiftClk) disable iff (frameRst)
      $rose(conversion_strobe_out)
         |=> (!conversion_strobe_out && outCnt_ff == 4'hB
              && serialOut == $past(resultSh_ff[11]));
   endproperty
   a_strobeMsb: assert property (p_strobeMsb)
      else $error("strobe not one period before the MSB");

   property p_noStrobeIdle;
      @(negedge shiftClk) disable iff (frameRst)
      (startFire && cfgMode != MODE_EXT_CLK) |=> !conversion_strobe_out;
   endproperty
   a_noStrobeIdle: assert property (p_noStrobeIdle)
      else $error("strobe outside external clock mode");

   // reference side checks
   property p_routeSingle;
      @(posedge ref_clk) disable iff (!reset_n)
      (cfgNew && newSetup.inputPairingSelect)
         |=> (route_ff.minusGround && route_ff.plusChannel
              == {setup_ff.channelSelect[1:0], setup_ff.channelSelect[2]});
   endproperty
   a_routeSingle: assert property (p_routeSingle)
      else $error("single-ended channel map wrong");

   property p_routeDiff;
      @(posedge ref_clk) disable iff (!reset_n)
      (cfgNew && !newSetup.inputPairingSelect)
         |=> (!route_ff.minusGround && route_ff.plusChannel[2:1] == route_ff.minusChannel[2:1]
              && route_ff.plusChannel[0] == setup_ff.channelSelect[2]
              && route_ff.minusChannel[0] != setup_ff.channelSelect[2]);
   endproperty
   a_routeDiff: assert property (p_routeDiff)
      else $error("differential pair map wrong");
endmodule

/* bench/spi_host_model.sv */
// host side model: mode zero shift master that frames, clocks and samples the link
module spi_host_model (
   output logic shiftClk,
   output logic selectN,
   output logic serialIn,
   input wire logic serialOut,
   input wire logic strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic rxBit [1:64];
   logic sbBit [1:64];
   int nGlitch;
   // idle link: clock parked low between frames, select high
   initial begin
      shiftClk = 1'b0;
      selectN = 1'b1;
      serialIn = 1'b1;
      nGlitch = 0;
   end
   // one framed burst of n bits, bit n-1 of tx first, 30 ns shift period
   task automatic frame(input logic [63:0] tx, input int n);
      int j;
      selectN = 1'b0;
      for (j = 1; j <= n; j++) begin
         // polarity zero, phase zero: data set while clock low
         #5 serialIn = tx[n-j];
         #10 shiftClk = 1'b1;
         rxBit[j] = serialOut;
         sbBit[j] = strobe;
         // outputs must hold through the high phase
         #14 if (serialOut !== rxBit[j] || strobe !== sbBit[j]) nGlitch++;
         #1 shiftClk = 1'b0;
      end
      #10 selectN = 1'b1;
      // released line: no stale level left behind
      serialIn = ~serialIn;
   endtask
endmodule

/* bench/tb_adc_serial_control.sv */
// self-checking bench for the serial converter control front end
module tb_adc_serial_control;
   import adc_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, reset_n, shiftClk, selectN, serialIn, serialOut, serialOutOe;
   logic strobe, strobeOe, sampleValid, sampleReady, convStart;
   logic [RESULT_BITS-1:0] sampleData, r1, r2;
   logic [RESULT_BITS-1:0] accQ [$];
   logic [63:0] rxv, sbv, expD, expS;
   setup_s setupSeen;
   route_s route;
   int n_mismatch, tests_run, nConv, expConv, nOeLow, i, j;

   adc_serial_control uut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .shiftClk(shiftClk),
      .selectN(selectN),
      .serialIn(serialIn),
      .serialOut(serialOut),
      .serialOutOe(serialOutOe),
      .conversion_strobe_out(strobe),
      .strobeOe(strobeOe),
      .sampleData(sampleData),
      .sampleValid(sampleValid),
      .sampleReady(sampleReady),
      .setup_ff(setupSeen),
      .route_ff(route),
      .convStart_ff(convStart)
   );

   spi_host_model host (
      .shiftClk(shiftClk),
      .selectN(selectN),
      .serialIn(serialIn),
      .serialOut(serialOut),
      .strobe(strobe)
   );

   // 125 MHz main clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // words the fifo took, in order, plus setup pulses seen
   always @(posedge ref_clk) begin
      if (sampleValid === 1'b1 && sampleReady === 1'b1) accQ.push_back(sampleData);
      if (convStart === 1'b1) nConv++;
   end

   // drive enables must stand after every falling shift edge inside a frame
   always @(negedge shiftClk) begin
      #2;
      if (selectN === 1'b0 && {serialOutOe, strobeOe} !== 2'b11) nOeLow++;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // valid held for n cycles; data moves on every cycle, the monitor keeps what was taken
   task automatic offer(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         sampleValid = 1'b1;
         sampleData = sampleData + 12'h9D3;
      end
      @(negedge ref_clk);
      sampleValid = 1'b0;
   endtask

   // gather what the host sampled over n rising edges
   task automatic grab(input int n);
      rxv = '0;
      sbv = '0;
      for (j = 1; j <= n; j++) begin
         rxv[j] = host.rxBit[j];
         sbv[j] = host.sbBit[j];
      end
   endtask

   // one conversion: lead zeros, setup byte, two result bytes
   task automatic convert(input logic [7:0] cfg, input int lead);
      logic [11:0] res;
      logic [2:0] pl;
      res = 12'h000;
      if (cfg[1] && accQ.size() > 0) res = accQ.pop_front();
      if (cfg[1]) expConv++;
      if (!cfg[3]) res[11] = ~res[11];
      // fresh byte, then sixteen clocks for the result
      host.frame({40'h0, cfg, 16'h0000}, lead + 24);
      grab(lead + 24);
      expD = '0;
      expS = '0;
      for (j = lead + 10; j <= lead + 21; j++) expD[j] = res[lead+21-j];
      expS[lead+9] = (cfg[1:0] == 2'b11);
      check(sbv, expS);
      check(rxv, expD);
      // select release lands in the design after this time step, so wait first
      repeat (6) @(negedge ref_clk);
      check({serialOutOe, strobeOe}, 2'h0);
      check(setupSeen, cfg[6:0]);
      pl = {cfg[5], cfg[4], cfg[6]};
      if (cfg[2]) check({route.plusChannel, route.minusGround}, {pl, 1'b1});
      else check(route, {pl, pl ^ 3'h1, 1'b0});
   endtask

   // watchdog, far beyond the expected run of about 20 us
   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end

   initial begin
      reset_n = 1'b0;
      sampleValid = 1'b0;
      sampleData = 12'h000;
      n_mismatch = 0;
      tests_run = 0;
      nConv = 0;
      expConv = 0;
      nOeLow = 0;
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      check(setupSeen, SETUP_RESET[6:0]);
      check(route, 7'h02);
      check({sampleReady, serialOutOe, strobeOe, convStart}, 4'h8);
      // fill until refused
      offer(12);
      check(sampleReady, 1'b0);
      check(accQ.size() >= FIFO_DEPTH, 1'b1);
      // every selector code in both pairings, with leading zeros
      for (i = 0; i < 16; i++) begin
         if (i == 8) offer(12);
         convert({1'b1, i[2:0], i[0], ~i[3], 2'b11}, i % 3);
      end
      // input held high: back to back conversions on channel seven
      offer(4);
      r1 = accQ.pop_front();
      r2 = accQ.pop_front();
      expConv += 2;
      host.frame('1, 36);
      grab(36);
      expD = '0;
      expS = '0;
      for (j = 10; j <= 21; j++) expD[j] = r1[21-j];
      for (j = 25; j <= 36; j++) expD[j] = r2[36-j];
      expS[9] = 1'b1;
      expS[24] = 1'b1;
      check(sbv, expS);
      check(rxv, expD);
      repeat (6) @(negedge ref_clk);
      check(setupSeen, 7'h7F);
      check({route.plusChannel, route.minusGround}, 4'hF);
      // a partial byte leaves the setup alone
      host.frame(64'h15, 5);
      repeat (6) @(negedge ref_clk);
      check(setupSeen, 7'h7F);
      // drain the buffer with external clock conversions on channel zero
      while (accQ.size() > 0) convert(8'h8F, 0);
      // power-down and internal clock codes: no strobe, nothing to send
      for (i = 0; i < 3; i++) convert({6'h37, i[1:0]}, 1);
      check(nConv, expConv);
      check(host.nGlitch, 0);
      check(nOeLow, 0);
      summarize();
   end
endmodule
